// File: hw/sram_page_regs.vh
`ifndef SRAM_PAGE_REGS_VH
`define SRAM_PAGE_REGS_VH
`define ADDR_CURRENT_PAGE 8'hD0
`define ADDR_STACK_PAGE 8'hD1
`define ADDR_INDEX_PAGE 8'hD3
`define ADDR_MOVE_READ_PAGE 8'hD4
`define ADDR_MOVE_WRITE_PAGE 8'hD5
`define ADDR_FLAGS 8'hF7
`define RESET_PAGE 3'h0
`define RESET_FLAGS 8'h02
`define FLAG_MODE_HI 7
`define FLAG_MODE_LO 6
`define FLAG_BANK 4
`define FLAG_CARRY 2
`define FLAG_ZERO 1
`define FLAG_GIE 0
`define MODE_ZERO 2'h0
`define MODE_STACK_ISR 2'h1
`define MODE_INDEX 2'h2
`define MODE_STACK 2'h3
`define KIND_DIRECT 3'h0
`define KIND_INDEXED 3'h1
`define KIND_STACK 3'h2
`define KIND_MOVE_PTR 3'h3
`define KIND_MOVE_READ 3'h4
`define KIND_MOVE_WRITE 3'h5
`define FLAG_OP_AND 2'h1
`define FLAG_OP_OR 2'h2
`define FLAG_OP_XOR 2'h3
`endif

// File: hw/page_pointer_reg.v
`timescale 1ns/1ps
// one three-bit page pointer; upper bits do not exist
module page_pointer_reg (
  input wire clock,
  input wire srst,
  input wire clock_enable,
  input wire write_strobe,
  input wire [7:0] write_data,
  output reg [2:0] page
);
  always @(posedge clock) begin
    if (srst) begin
      page <= 3'h0;
    end else if (clock_enable && write_strobe) begin
      page <= write_data[2:0];
    end
  end
endmodule // page_pointer_reg

// File: hw/sram_page_address_select.v
`timescale 1ns/1ps
`include "sram_page_regs.vh"
module sram_page_address_select (
  input wire clock,
  input wire srst,
  input wire clock_enable,
  input wire reg_write,
  input wire reg_read,
  input wire [7:0] reg_address,
  input wire [7:0] reg_write_data,
  output reg [7:0] reg_read_data,
  output wire [8:0] reg_full_address,
  output wire reg_config_space,
  input wire [2:0] access_kind,
  input wire [7:0] access_offset,
  output reg [10:0] sram_address,
  input wire [1:0] flag_op,
  input wire [7:0] flag_operand,
  input wire alu_update,
  input wire alu_carry,
  input wire alu_zero,
  input wire interrupt_entry,
  input wire interrupt_return,
  input wire [7:0] restored_flags,
  output wire [7:0] saved_flags,
  output wire [7:0] flags,
  output wire [1:0] paging_mode_field,
  output wire register_bank_select,
  output wire global_interrupt_enable,
  output wire carry_flag,
  output wire zero_flag
);
  reg [2:0] current_page_pointer;
  reg [7:0] core_flag_register;
  reg [7:0] next_flags;
  reg [2:0] page;
  wire [2:0] stack_page_pointer;
  wire [2:0] index_page_pointer;
  wire [2:0] move_read_page_pointer;
  wire [2:0] move_write_page_pointer;
  wire [4:0] page_selects;
  // decoded twice: pointer write strobes and bank-independent flag access
  function hit;
    input [7:0] address;
    input [7:0] target;
    input bank;
    input any_bank;
    begin
      hit = (address == target) && (any_bank || !bank);
    end
  endfunction
  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1) begin : pointer_regs
      localparam [7:0] target = (g == 0) ? `ADDR_CURRENT_PAGE : (g == 1) ? `ADDR_STACK_PAGE :
        (g == 2) ? `ADDR_INDEX_PAGE : (g == 3) ? `ADDR_MOVE_READ_PAGE : `ADDR_MOVE_WRITE_PAGE;
      assign page_selects[g] = reg_write && hit(reg_address, target, register_bank_select, 1'b0);
    end
  endgenerate
  always @(posedge clock) begin
    if (srst) begin
      current_page_pointer <= `RESET_PAGE;
    end else if (clock_enable && page_selects[0]) begin
      current_page_pointer <= reg_write_data[2:0];
    end
  end
  page_pointer_reg stack_reg (
    .clock(clock),
    .srst(srst),
    .clock_enable(clock_enable),
    .write_strobe(page_selects[1]),
    .write_data(reg_write_data),
    .page(stack_page_pointer)
  );
  page_pointer_reg index_reg (
    .clock(clock),
    .srst(srst),
    .clock_enable(clock_enable),
    .write_strobe(page_selects[2]),
    .write_data(reg_write_data),
    .page(index_page_pointer)
  );
  page_pointer_reg move_read_reg (
    .clock(clock),
    .srst(srst),
    .clock_enable(clock_enable),
    .write_strobe(page_selects[3]),
    .write_data(reg_write_data),
    .page(move_read_page_pointer)
  );
  page_pointer_reg move_write_reg (
    .clock(clock),
    .srst(srst),
    .clock_enable(clock_enable),
    .write_strobe(page_selects[4]),
    .write_data(reg_write_data),
    .page(move_write_page_pointer)
  );
  // flag register: a plain write at its address is ignored, only logic ops, interrupt entry/return and alu updates change it
  always @* begin
    next_flags = core_flag_register;
    if (interrupt_entry) begin
      next_flags = 8'h00;
    end else if (interrupt_return) begin
      next_flags = restored_flags;
    end else if (flag_op != 2'h0) begin
      case (flag_op)
        `FLAG_OP_AND: next_flags = core_flag_register & flag_operand;
        `FLAG_OP_OR: next_flags = core_flag_register | flag_operand;
        `FLAG_OP_XOR: next_flags = core_flag_register ^ flag_operand;
        default: next_flags = core_flag_register;
      endcase
    end else if (alu_update) begin
      next_flags[`FLAG_CARRY] = alu_carry;
      next_flags[`FLAG_ZERO] = alu_zero;
    end
  end
  always @(posedge clock) begin
    if (srst) begin
      core_flag_register <= `RESET_FLAGS;
    end else if (clock_enable) begin
      core_flag_register <= next_flags;
    end
  end
  // core pushes this value before entry clears the register
  assign saved_flags = core_flag_register;
  assign flags = core_flag_register;
  assign paging_mode_field = core_flag_register[`FLAG_MODE_HI:`FLAG_MODE_LO];
  assign register_bank_select = core_flag_register[`FLAG_BANK];
  assign global_interrupt_enable = core_flag_register[`FLAG_GIE];
  assign carry_flag = core_flag_register[`FLAG_CARRY];
  assign zero_flag = core_flag_register[`FLAG_ZERO];
  assign reg_full_address = {register_bank_select, reg_address};
  assign reg_config_space = register_bank_select;
  // read data registered one cycle after the read strobe
  always @(posedge clock) begin
    if (srst) begin
      reg_read_data <= 8'h00;
    end else if (clock_enable && reg_read) begin
      if (hit(reg_address, `ADDR_FLAGS, register_bank_select, 1'b1)) begin
        reg_read_data <= core_flag_register;
      end else if (register_bank_select) begin
        reg_read_data <= 8'h00;
      end else begin
        case (reg_address)
          `ADDR_CURRENT_PAGE: reg_read_data <= {5'h00, current_page_pointer};
          `ADDR_STACK_PAGE: reg_read_data <= {5'h00, stack_page_pointer};
          `ADDR_INDEX_PAGE: reg_read_data <= {5'h00, index_page_pointer};
          `ADDR_MOVE_READ_PAGE: reg_read_data <= {5'h00, move_read_page_pointer};
          `ADDR_MOVE_WRITE_PAGE: reg_read_data <= {5'h00, move_write_page_pointer};
          default: reg_read_data <= 8'h00;
        endcase
      end
    end
  end
  // page choice is combinational so a just-written pointer applies next access
  always @* begin
    case (access_kind)
      `KIND_STACK: page = stack_page_pointer;
      `KIND_DIRECT: page = paging_mode_field[1] ? current_page_pointer : 3'h0;
      `KIND_INDEXED: begin
        case (paging_mode_field)
          `MODE_ZERO: page = 3'h0;
          `MODE_STACK_ISR: page = stack_page_pointer;
          `MODE_INDEX: page = index_page_pointer;
          `MODE_STACK: page = stack_page_pointer;
          default: page = 3'h0;
        endcase
      end
      `KIND_MOVE_PTR: page = paging_mode_field[1] ? current_page_pointer : 3'h0;
      `KIND_MOVE_READ: page = move_read_page_pointer;
      `KIND_MOVE_WRITE: page = move_write_page_pointer;
      default: page = 3'h0;
    endcase
  end
  // address registered; it follows the access kind presented one cycle earlier
  always @(posedge clock) begin
    if (srst) begin
      sram_address <= 11'h000;
    end else if (clock_enable) begin
      sram_address <= {page, access_offset};
    end
  end
endmodule // sram_page_address_select

// File: bench/page_select_checker_assertions.sv
`timescale 1ns/1ps
`include "sram_page_regs.vh"
module page_select_checker (
  input wire clock,
  input wire srst,
  input wire clock_enable,
  input wire reg_write,
  input wire alu_update,
  input wire [7:0] reg_address,
  input wire [2:0] access_kind,
  input wire [7:0] access_offset,
  input wire [10:0] sram_address,
  input wire [1:0] flag_op,
  input wire interrupt_entry,
  input wire interrupt_return,
  input wire [7:0] restored_flags,
  input wire [7:0] flags,
  input wire [8:0] reg_full_address
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // higher-priority flag sources masked out
  wire calm = clock_enable && !interrupt_entry && !interrupt_return;
  offset_pass_a: assert property (clock_enable |=> sram_address[7:0] == $past(access_offset))
    else $error("offset lost");
  index_zero_a: assert property (clock_enable && access_kind == `KIND_INDEXED && flags[7:6] == `MODE_ZERO
    |=> sram_address[10:8] == 3'h0) else $error("indexed page not zero");
  direct_zero_a: assert property (clock_enable && access_kind == `KIND_DIRECT && !flags[7]
    |=> sram_address[10:8] == 3'h0) else $error("direct page not zero");
  pointer_fetch_a: assert property (clock_enable && access_kind == `KIND_MOVE_PTR && !flags[7]
    |=> sram_address[10:8] == 3'h0) else $error("pointer page wrong");
  isr_clear_a: assert property (clock_enable && interrupt_entry |=> flags == 8'h00)
    else $error("flags not cleared");
  isr_restore_a: assert property (clock_enable && interrupt_return && !interrupt_entry
    |=> flags == $past(restored_flags)) else $error("flags not restored");
  flag_write_a: assert property (calm && reg_write && reg_address == `ADDR_FLAGS && flag_op == 2'h0
    && !alu_update |=> $stable(flags)) else $error("flag write took effect");
  bank_bit_a: assert property (reg_full_address == {flags[4], reg_address})
    else $error("bank bit not ninth bit");
endmodule // page_select_checker
bind sram_page_address_select page_select_checker page_select_checker_i (.clock, .srst, .clock_enable,
  .reg_write, .alu_update, .reg_address, .access_kind, .access_offset, .sram_address, .flag_op,
  .interrupt_entry, .interrupt_return, .restored_flags, .flags, .reg_full_address);

// File: bench/flag_stack_model.sv
`timescale 1ns/1ps
// core side: flag byte pushed on entry, popped on return
module flag_stack_model (
  input wire clock,
  input wire push,
  input wire [7:0] din,
  output reg [7:0] dout = 8'hA5
);
  // one level only, nesting would need a real stack
  always @(posedge clock) begin
    if (push) begin
      dout <= din;
    end
  end
endmodule // flag_stack_model

// File: bench/tb_top.sv
`timescale 1ns/1ps
`include "sram_page_regs.vh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; \
  $display("wrong value at %0t: %h vs %h", $time, g, e); end end
module tb_top;
  reg clock = 0, srst = 1, reg_write = 0, reg_read = 0, alu_update = 0, interrupt_entry = 0, interrupt_return = 0;
  reg [7:0] reg_address = 0, reg_write_data = 0, access_offset = 0, f = 8'h02, sf = 8'hA5;
  reg [2:0] access_kind = 0, pp [0:7];
  reg [1:0] flag_op = 0;
  reg [3:0] mode = 0, pm = 0;
  reg [10:0] e, q [$];
  wire [7:0] reg_read_data, restored_flags, saved_flags, flags;
  wire [10:0] sram_address;
  integer seed = 32'hDA6E, err_total = 0, tests_run = 0, cyc = 0, i, j;
  sram_page_address_select sram_page_address_select_i (.clock, .srst, .clock_enable(1'b1), .reg_write,
    .reg_read, .reg_address, .reg_write_data, .reg_read_data, .reg_full_address(), .reg_config_space(),
    .access_kind, .access_offset, .sram_address, .flag_op, .flag_operand(reg_write_data), .alu_update,
    .alu_carry(reg_write_data[2]), .alu_zero(reg_write_data[1]), .interrupt_entry, .interrupt_return,
    .restored_flags, .saved_flags, .flags, .paging_mode_field(), .register_bank_select(),
    .global_interrupt_enable(), .carry_flag(), .zero_flag());
  flag_stack_model flag_stack_model_i (.clock, .push(interrupt_entry), .din(saved_flags), .dout(restored_flags));
  always #5 clock = ~clock;
  function [2:0] pg(input [2:0] k);
    case (k)
      `KIND_STACK: pg = pp[1];
      `KIND_INDEXED: pg = f[6] ? pp[1] : f[7] ? pp[3] : 3'h0;
      `KIND_MOVE_READ: pg = pp[4];
      `KIND_MOVE_WRITE: pg = pp[5];
      default: pg = f[7] ? pp[0] : 3'h0;
    endcase
  endfunction
  // m: 1 write, 2 read, 3 access, 5..7 flag logic, 8 entry, 9 return, 10 alu
  task go(input [3:0] m, input [7:0] a, input [7:0] d);
    reg hit;
    hit = !f[4] && a[7:3] == 5'h1A && a[2:0] != 3'h2 && a[2:0] < 3'h6;
    @(posedge clock);
    mode <= m;
    reg_write <= m == 1;
    reg_read <= m == 2;
    reg_address <= a;
    reg_write_data <= d;
    access_kind <= a[2:0];
    access_offset <= d;
    flag_op <= (m > 4 && m < 8) ? m[1:0] : 2'h0;
    interrupt_entry <= m == 8;
    interrupt_return <= m == 9;
    alu_update <= m == 10;
    if (m == 2) q.push_back(a == `ADDR_FLAGS ? {3'h0, f} : hit ? {8'h00, pp[a[2:0]]} : 11'h000);
    if (m == 3) q.push_back({pg(a[2:0]), d});
    if (m == 1 && hit) pp[a[2:0]] = d[2:0];
    if (m > 4 && m < 8) f = m == 5 ? f & d : m == 6 ? f | d : f ^ d;
    if (m == 10) f[2:1] = d[2:1];
    sf = m == 8 ? f : sf;
    f = m == 8 ? 8'h00 : m == 9 ? sf : f;
  endtask
  task final_report;
    if (err_total == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // results land two edges after issue, so compare against the oldest note
  always @(posedge clock) begin
    cyc <= cyc + 1;
    pm <= mode;
    if (pm == 2 || pm == 3) begin
      e = q.pop_front();
      if (pm == 2) `CHK({3'h0, reg_read_data}, e)
      else `CHK(sram_address, e)
    end
    if (cyc == 4000) begin
      err_total++;
      final_report;
    end
  end
  initial begin
    for (i = 0; i < 8; i++) pp[i] = 3'h0;
    repeat (8) @(posedge clock);
    srst <= 0;
    go(2, `ADDR_FLAGS, 0);
    go(1, `ADDR_FLAGS, 8'hFF);
    for (i = 0; i < 8; i++) go(2, 8'hD0 + i, 0);
    for (i = 0; i < 6; i++) go(1, 8'hD0 + i, $random(seed));
    for (i = 0; i < 8; i++) go(2, 8'hD0 + i, 0);
    for (i = 0; i < 4; i++) begin
      go(7, 0, {f[7:6] ^ i[1:0], 6'h00});
      for (j = 0; j < 6; j++) go(3, j, $random(seed));
      go(1, `ADDR_STACK_PAGE, $random(seed));
      go(3, `KIND_STACK, $random(seed));
    end
    go(6, 0, 8'h10);
    go(1, `ADDR_STACK_PAGE, 8'h07);
    go(2, `ADDR_STACK_PAGE, 0);
    go(2, `ADDR_FLAGS, 0);
    go(5, 0, 8'hEF);
    go(10, 0, $random(seed));
    go(2, `ADDR_FLAGS, 0);
    go(8, 0, 0);
    go(3, `KIND_INDEXED, $random(seed));
    go(9, 0, 0);
    go(2, `ADDR_FLAGS, 0);
    go(0, 0, 0);
    go(0, 0, 0);
    // let the checking process finish its last compare before the verdict
    @(negedge clock);
    final_report;
  end
endmodule // tb_top
